// *** src/flsq_top.sv ***
// Top: command-frame sequencer of a serial flash, sampled on the system clock
`timescale 1ns/1ps

// Operation
// - Plain read: 8/4/2 opcode clocks plus address bits over protocol lanes.
// - Fast read uses the same pre-data counts as plain read.
// - Dual-output read only in extended and dual; address on protocol lanes.
// - Dual I/O read puts the address on two lanes, even extended.
// - Quad-output read only in extended and quad; address on protocol lanes.
// - Quad I/O word read carries address on four lanes in both protocols.
// - Double-rate fast read samples address on both edges; counts halve.
// - Double-rate dual-output read: extended and dual only.
// - Double-rate dual I/O read: divisor four extended, eight in dual protocol.
// - Double-rate quad-output read: extended and quad only.
// - Double-rate quad I/O read: four lanes both edges, divisor eight.
// - Opcode enters on lane 0, lanes 1:0 or lanes 3:0 by protocol.
// - A rising clock edge past the opcode drops the command; latch stays unchanged.
// - Write-enable opcode sets the write enable latch.
// - Write-disable clears the latch unless protection error; clear-flag clears both.
// - Register reads: extended outputs on lane 1; dual/quad share lanes.
// - Deselect during output ends the frame; driving stops at once.
// - Status and flag-status reads served any time, repeating continuously.
// - Nonvolatile configuration read outputs zero after its 16 bits.
// - Nonvolatile fields read as supplied, reserved mask is zero; least significant byte first.
// - Volatile, enhanced volatile and extended address reads repeat the byte.
// - Default address is three bytes, latched on rising clock edges.
// - Four-byte read variants always take a 32-bit address.
// - Double-rate opcodes always double rate; others only when configured.
module flsq_top
  import flsq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial link pins
  input  wire logic        sel_n_i,
  input  wire logic        sck_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_n_o,
  // Configuration
  input  wire flsq_proto_t proto_i,
  input  wire logic        dtr_en_i,
  input  wire logic        addr4_en_i,
  input  wire logic        prot_err_i,
  // Register contents to be read out
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  flag_i,
  input  wire logic [15:0] nvcfg_i,
  input  wire logic [7:0]  vcfg_i,
  input  wire logic [7:0]  evcfg_i,
  input  wire logic [7:0]  extaddr_i,
  // Latch, command pulses and read request
  output logic             wel_o,
  output logic             clr_flag_o,
  output logic             rd_start_o,
  output flsq_rdreq_t      rd_req_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic       sel_s, sck_s, sck_q, next_sck_q, rise, fall;
  logic [3:0] io_s;

  flsq_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sel_n_i, sck_i, io_i}),
    .q_o   (pins_s)
  );

  assign sel_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign io_s  = pins_s[3:0];

  // Link clock edges seen at the system clock
  always_comb begin
    next_sck_q = sck_s;
    rise       = sck_s & ~sck_q;
    fall       = ~sck_s & sck_q;
  end

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  // Address lanes follow the protocol unless the opcode fixes them
  function automatic flsq_dec_t decode(logic [7:0] op, flsq_proto_t p, logic dtr_cfg,
                                       logic a4_cfg);
    flsq_dec_t d;
    d = '{kind: K_READ, rsel: R_STATUS, alanes: flsq_lanes(p), dtr: dtr_cfg, a4: a4_cfg};
    unique case (op)
      OP_READ, OP_FAST: ;
      OP_READ4, OP_FAST4: d.a4 = 1'b1;
      OP_DTRF: d.dtr = 1'b1;
      OP_DTRF4: begin d.dtr = 1'b1; d.a4 = 1'b1; end
      OP_DOF, OP_DOF4, OP_DTRDO: begin
        if (p == FLSQ_QUAD) d.kind = K_NONE;
        d.a4  = a4_cfg | (op == OP_DOF4);
        d.dtr = dtr_cfg | (op == OP_DTRDO);
      end
      OP_DIO, OP_DIO4, OP_DTRDIO, OP_DTRDIO4: begin
        if (p == FLSQ_QUAD) d.kind = K_NONE;
        d.alanes = 3'h2;
        d.a4     = a4_cfg | (op == OP_DIO4) | (op == OP_DTRDIO4);
        d.dtr    = dtr_cfg | (op == OP_DTRDIO) | (op == OP_DTRDIO4);
      end
      OP_QOF, OP_QOF4, OP_DTRQO: begin
        if (p == FLSQ_DUAL) d.kind = K_NONE;
        d.a4  = a4_cfg | (op == OP_QOF4);
        d.dtr = dtr_cfg | (op == OP_DTRQO);
      end
      OP_QIO, OP_QIO4, OP_QWORD, OP_DTRQIO, OP_DTRQIO4: begin
        if (p == FLSQ_DUAL) d.kind = K_NONE;
        d.alanes = 3'h4;
        d.a4     = a4_cfg | (op == OP_QIO4) | (op == OP_DTRQIO4);
        d.dtr    = (op == OP_QWORD) ? 1'b0 :
                   (dtr_cfg | (op == OP_DTRQIO) | (op == OP_DTRQIO4));
      end
      OP_WREN: d.kind = K_WREN;
      OP_WRDI: d.kind = K_WRDI;
      OP_CLRF: d.kind = K_CLRF;
      OP_RDSR:  begin d.kind = K_RREG; d.rsel = R_STATUS; end
      OP_RDFSR: begin d.kind = K_RREG; d.rsel = R_FLAG;   end
      OP_RDNV:  begin d.kind = K_RREG; d.rsel = R_NVCFG;  end
      OP_RDVC:  begin d.kind = K_RREG; d.rsel = R_VCFG;   end
      OP_RDEVC: begin d.kind = K_RREG; d.rsel = R_EVCFG;  end
      OP_RDEXA: begin d.kind = K_RREG; d.rsel = R_EXTA;   end
      default: d.kind = K_NONE;
    endcase
    return d;
  endfunction

  // Shift lane bits into a word, first bit on the highest lane
  function automatic logic [31:0] shift_in(logic [31:0] v, logic [3:0] io, logic [2:0] ln);
    logic [31:0] r;
    unique case (ln)
      3'h4:    r = {v[27:0], io[3:0]};
      3'h2:    r = {v[29:0], io[1:0]};
      default: r = {v[30:0], io[0]};
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  flsq_state_t st, next_st;
  flsq_dec_t   dec, next_dec, d;
  logic [7:0]  opc, next_opc, reg_byte;
  logic [6:0]  edges, next_edges, cx, next_cx, abits, next_abits;
  logic [31:0] addr, next_addr;
  logic [5:0]  acnt, next_acnt;
  logic [4:0]  pos, next_pos;
  logic        wel, next_wel, clrf, next_clrf, rdst, next_rdst;
  logic [3:0]  io, next_io, oen, next_oen, ser_lanes;
  flsq_rdreq_t req, next_req;
  logic [2:0]  plane;

  // Status byte carries the live write enable latch
  always_comb begin
    unique case (dec.rsel)
      R_STATUS: reg_byte = {status_i[7:STATUS_WEL_BIT+1], wel, status_i[STATUS_WEL_BIT-1:0]};
      R_FLAG:   reg_byte = flag_i;
      R_VCFG:   reg_byte = vcfg_i;
      R_EVCFG:  reg_byte = evcfg_i;
      R_EXTA:   reg_byte = extaddr_i;
      default:  reg_byte = 8'h00;
    endcase
  end

  flsq_regser u_ser (
    .byte_i  (reg_byte),
    .nv_i    (nvcfg_i),
    .is_nv_i (dec.rsel == R_NVCFG),
    .pos_i   (pos),
    .proto_i (proto_i),
    .lanes_o (ser_lanes)
  );

  // Sequencer; protocol inputs are assumed steady during a frame
  always_comb begin
    next_st = st;  next_dec = dec;  next_opc = opc;  next_edges = edges;
    next_cx = cx;  next_abits = abits;  next_addr = addr;  next_acnt = acnt;
    next_pos = pos;  next_wel = wel;  next_io = io;  next_oen = oen;  next_req = req;
    next_clrf = 1'b0;
    next_rdst = 1'b0;
    plane     = flsq_lanes(proto_i);
    d         = decode(opc, proto_i, dtr_en_i, addr4_en_i);
    unique case (st)
      ST_IDLE: if (!sel_s) begin
        next_st = ST_OPC;  next_opc = 8'h00;  next_edges = 7'h00;
        next_addr = 32'h0; next_acnt = 6'h00; next_pos = 5'h00;
      end
      ST_OPC: if (sel_s) begin
        next_st = ST_IDLE;
      end else if (rise) begin
        next_opc   = 8'(shift_in({24'h0, opc}, io_s, plane));
        next_edges = 7'(edges + 7'h01);
        if (next_edges == flsq_per_lane(OPC_BITS, plane, 1'b0)) begin
          d        = decode(next_opc, proto_i, dtr_en_i, addr4_en_i);
          next_dec = d;
          next_abits = d.a4 ? ABITS_4B : ABITS_3B;
          next_cx  = 7'((proto_i == FLSQ_QUAD ? CX_BASE_QUAD :
                         proto_i == FLSQ_DUAL ? CX_BASE_DUAL : CX_BASE_EXT)
                        + (flsq_per_lane(next_abits, d.alanes, d.dtr) >> // Dual: /8
                           (proto_i == FLSQ_DUAL && d.dtr &&
                            next_opc inside {OP_DIO, OP_DIO4, OP_DTRDIO, OP_DTRDIO4})));
          unique case (d.kind)
            K_READ:  next_st = ST_ADDR;
            K_WREN, K_WRDI, K_CLRF: next_st = ST_CMDEND;
            K_RREG: begin
              next_st  = ST_REGOUT;
              next_oen = (proto_i == FLSQ_QUAD) ? OEN_QUAD :
                         (proto_i == FLSQ_DUAL) ? OEN_DUAL : OEN_EXT;
            end
            default: next_st = ST_SKIP;
          endcase
        end
      end
      ST_ADDR: if (sel_s) begin
        next_st = ST_IDLE;
      end else begin
        // Rising edges latch until the address is complete; falling ones only at double rate
        if ((rise | (dec.dtr & fall)) &&
            ({1'b0, acnt} < flsq_per_lane(abits, dec.alanes, 1'b0))) begin
          next_addr = shift_in(addr, io_s, dec.alanes);
          next_acnt = 6'(acnt + 6'h01);
        end
        if (rise) begin
          next_edges = 7'(edges + 7'h01);
          if (next_edges == 7'(cx + 7'h01)) begin
            next_st   = ST_DATA;
            next_rdst = 1'b1;
            next_req  = '{opcode: opc, addr: next_addr, proto: proto_i, dtr: dec.dtr,
                          abits: abits, cx: cx};
          end
        end
      end
      ST_DATA, ST_SKIP: if (sel_s) next_st = ST_IDLE;
      ST_CMDEND: if (sel_s) begin
        next_st = ST_IDLE;
        unique case (dec.kind)
          K_WREN:  next_wel = 1'b1;
          K_WRDI:  if (!prot_err_i) next_wel = 1'b0;
          default: begin next_wel = 1'b0; next_clrf = 1'b1; end
        endcase
      end else if (rise) begin
        next_st = ST_SKIP;
      end
      ST_REGOUT: if (sel_s) begin
        next_st = ST_IDLE;
        next_oen = OEN_NONE;
        next_io  = 4'h0;
      end else begin
        next_io = ser_lanes & ~oen;
        if (fall) begin
          if (dec.rsel != R_NVCFG) begin
            next_pos = 5'(pos + {2'h0, plane});
          end else if (pos < NV_BITS) begin
            next_pos = 5'(pos + {2'h0, plane});
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // State registers; the latch starts cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;  dec <= '0;  opc <= 8'h00;  edges <= 7'h00;  cx <= 7'h00;
      abits <= 7'h00;  addr <= 32'h0;  acnt <= 6'h00;  pos <= 5'h00;
      wel <= 1'b0;  clrf <= 1'b0;  rdst <= 1'b0;  io <= 4'h0;  oen <= OEN_NONE;
      req <= '0;  sck_q <= 1'b0;
    end else begin
      st <= next_st;  dec <= next_dec;  opc <= next_opc;  edges <= next_edges;
      cx <= next_cx;  abits <= next_abits;  addr <= next_addr;  acnt <= next_acnt;
      pos <= next_pos;  wel <= next_wel;  clrf <= next_clrf;  rdst <= next_rdst;
      io <= next_io;  oen <= next_oen;  req <= next_req;  sck_q <= next_sck_q;
    end
  end

  assign io_o       = io;
  assign io_oe_n_o  = oen;
  assign wel_o      = wel;
  assign clr_flag_o = clrf;
  assign rd_start_o = rdst;
  assign rd_req_o   = req;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_read_ext; rd_start_o && rd_req_o.opcode == OP_READ && rd_req_o.proto == FLSQ_EXT
    && rd_req_o.abits == ABITS_3B |-> rd_req_o.cx == 7'h1f; endproperty
  a_read_ext: assert property (p_read_ext) else $error("plain read count wrong");
  property p_fast_quad; rd_start_o && rd_req_o.opcode == OP_FAST4 && rd_req_o.proto == FLSQ_QUAD
    && !rd_req_o.dtr |-> rd_req_o.cx == 7'h09 && rd_req_o.abits == ABITS_4B; endproperty
  a_fast_quad: assert property (p_fast_quad) else $error("fast read count wrong");
  property p_dio_ext; rd_start_o && rd_req_o.opcode == OP_DIO && rd_req_o.proto == FLSQ_EXT
    && rd_req_o.abits == ABITS_3B && !rd_req_o.dtr |-> rd_req_o.cx == 7'h13; endproperty
  a_dio_ext: assert property (p_dio_ext) else $error("dual io count wrong");
  property p_dtr_quad; rd_start_o && rd_req_o.opcode == OP_DTRF4 && rd_req_o.proto == FLSQ_QUAD
    |-> rd_req_o.dtr && rd_req_o.cx == 7'h05; endproperty
  a_dtr_quad: assert property (p_dtr_quad) else $error("dtr read count wrong");
  property p_start_edge; $rose(rd_start_o) |-> edges == 7'(rd_req_o.cx + 7'h01)
    ##1 !rd_start_o; endproperty
  a_start_edge: assert property (p_start_edge) else $error("read start off count");
  property p_wel_set; $rose(wel_o) |-> $past(st) == ST_CMDEND && $past(opc) == OP_WREN;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set without enable");
  property p_skip_hold; st == ST_SKIP |=> $stable(wel_o) && !clr_flag_o; endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("dropped frame had effect");
  property p_wrdi_prot; $fell(wel_o) |-> $past(opc) == OP_CLRF || !$past(prot_err_i);
  endproperty
  a_wrdi_prot: assert property (p_wrdi_prot) else $error("latch cleared on error");
  property p_stop_drive; st == ST_REGOUT && sel_s |=> io_oe_n_o == OEN_NONE ##1
    io_oe_n_o == OEN_NONE; endproperty
  a_stop_drive: assert property (p_stop_drive) else $error("drive after deselect");
  property p_ext_lane; st == ST_REGOUT && proto_i == FLSQ_EXT && !sel_s |->
    io_oe_n_o == OEN_EXT; endproperty
  a_ext_lane: assert property (p_ext_lane) else $error("wrong output lane");
  property p_nv_zero; st == ST_REGOUT && dec.rsel == R_NVCFG && pos == NV_BITS && !sel_s
    |=> st != ST_REGOUT || io_o == 4'h0; endproperty
  a_nv_zero: assert property (p_nv_zero) else $error("padding not zero");
  property p_early_end; st == ST_OPC && sel_s |=> st == ST_IDLE && $stable(wel_o); endproperty
  a_early_end: assert property (p_early_end) else $error("early deselect acted");

  c_read:   cover property (rd_start_o);
  c_wel:    cover property ($rose(wel_o));
  c_regout: cover property (st == ST_REGOUT ##1 st == ST_IDLE);
  c_skip:   cover property (st == ST_SKIP);

endmodule // flsq_top

// *** src/flsq_pkg.sv ***
// Package: shared types, opcodes and constants of the flash command sequencer
package flsq_pkg;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FLSQ_EXT, FLSQ_DUAL, FLSQ_QUAD} flsq_proto_t;
  typedef enum logic [2:0] {K_NONE, K_READ, K_WREN, K_WRDI, K_CLRF, K_RREG} flsq_kind_t;
  typedef enum logic [2:0] {R_STATUS, R_FLAG, R_NVCFG, R_VCFG, R_EVCFG, R_EXTA} flsq_reg_t;
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_CMDEND, ST_SKIP,
                            ST_REGOUT} flsq_state_t;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h03, OP_READ4 = 8'h13, OP_FAST = 8'h0b, OP_FAST4 = 8'h0c;
  localparam logic [7:0] OP_DOF = 8'h3b, OP_DOF4 = 8'h3c, OP_DIO = 8'hbb, OP_DIO4 = 8'hbc;
  localparam logic [7:0] OP_QOF = 8'h6b, OP_QOF4 = 8'h6c, OP_QIO = 8'heb, OP_QIO4 = 8'hec;
  localparam logic [7:0] OP_QWORD = 8'he7, OP_DTRF = 8'h0d, OP_DTRF4 = 8'h0e;
  localparam logic [7:0] OP_DTRDO = 8'h3d, OP_DTRDIO = 8'hbd, OP_DTRDIO4 = 8'hbe;
  localparam logic [7:0] OP_DTRQO = 8'h6d, OP_DTRQIO = 8'hed, OP_DTRQIO4 = 8'hee;
  localparam logic [7:0] OP_WREN = 8'h06, OP_WRDI = 8'h04, OP_CLRF = 8'h50;
  localparam logic [7:0] OP_RDSR = 8'h05, OP_RDFSR = 8'h70, OP_RDNV = 8'hb5;
  localparam logic [7:0] OP_RDVC = 8'h85, OP_RDEVC = 8'h65, OP_RDEXA = 8'hc8;

  // ----------------------------------------------------------------
  // Counts, widths and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] CX_BASE_EXT = 7'h07, CX_BASE_DUAL = 7'h03, CX_BASE_QUAD = 7'h01;
  localparam logic [6:0] ABITS_3B = 7'h18, ABITS_4B = 7'h20, OPC_BITS = 7'h08;
  localparam logic [4:0] NV_BITS = 5'h10;
  localparam int         STATUS_WEL_BIT = 1;
  localparam logic [15:0] NVCFG_RSVD_MASK = 16'h0000;
  localparam logic [3:0] OEN_NONE = 4'hf, OEN_EXT = 4'hd, OEN_DUAL = 4'hc, OEN_QUAD = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  opcode;
    logic [31:0] addr;
    flsq_proto_t proto;
    logic        dtr;
    logic [6:0]  abits;
    logic [6:0]  cx;
  } flsq_rdreq_t;

  typedef struct packed {
    flsq_kind_t  kind;
    flsq_reg_t   rsel;
    logic [2:0]  alanes;
    logic        dtr;
    logic        a4;
  } flsq_dec_t;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  // Lanes carried by one edge in a protocol
  function automatic logic [2:0] flsq_lanes(flsq_proto_t p);
    return (p == FLSQ_QUAD) ? 3'h4 : (p == FLSQ_DUAL) ? 3'h2 : 3'h1;
  endfunction

  // Bits divided by lanes (and by two for double rate); divisors are powers of two
  function automatic logic [6:0] flsq_per_lane(logic [6:0] bits, logic [2:0] ln, logic dtr);
    logic [2:0] sh;
    sh = ((ln == 3'h4) ? 3'h2 : (ln == 3'h2) ? 3'h1 : 3'h0) + {2'h0, dtr};
    return bits >> sh;
  endfunction

endpackage

// *** src/flsq_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module flsq_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // flsq_sync

// *** src/flsq_regser.sv ***
// Read-register serialiser: stream position to lane bits
`timescale 1ns/1ps
module flsq_regser
  import flsq_pkg::*;
(
  // Register contents
  input  wire logic [7:0]  byte_i,
  input  wire logic [15:0] nv_i,
  input  wire logic        is_nv_i,
  // Stream position and protocol
  input  wire logic [4:0]  pos_i,
  input  wire flsq_proto_t proto_i,
  // Lane bits
  output logic      [3:0]  lanes_o
);

  // Bit k of the output stream; byte repeats, nonvolatile pads with zero
  function automatic logic sbit(logic [4:0] k, logic [7:0] b, logic [15:0] nv, logic isnv);
    logic r;
    r = b[3'h7 - k[2:0]];
    if (isnv) begin
      if (k < 5'h08) begin
        r = nv[4'(5'h07 - k)];
      end else if (k < NV_BITS) begin
        r = nv[4'(5'h17 - k)];
      end else begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  logic [15:0] nvr;

  // Reserved mask is zero, so fields read as supplied; first bit on the highest active lane
  always_comb begin
    nvr     = nv_i | NVCFG_RSVD_MASK;
    lanes_o = 4'h0;
    unique case (proto_i)
      FLSQ_EXT:  lanes_o[1] = sbit(pos_i, byte_i, nvr, is_nv_i);
      FLSQ_DUAL: begin
        lanes_o[1] = sbit(pos_i, byte_i, nvr, is_nv_i);
        lanes_o[0] = sbit(5'(pos_i + 5'h01), byte_i, nvr, is_nv_i);
      end
      default: begin
        lanes_o[3] = sbit(pos_i, byte_i, nvr, is_nv_i);
        lanes_o[2] = sbit(5'(pos_i + 5'h01), byte_i, nvr, is_nv_i);
        lanes_o[1] = sbit(5'(pos_i + 5'h02), byte_i, nvr, is_nv_i);
        lanes_o[0] = sbit(5'(pos_i + 5'h03), byte_i, nvr, is_nv_i);
      end
    endcase
  end

endmodule // flsq_regser

// *** tb/flsq_host.sv ***
// Host controller model: select, link clock and lanes
`timescale 1ns/1ps
module flsq_host (
  // Clock and lanes seen at the pins
  input  wire logic       clk_i,
  input  wire logic [3:0] io_i,
  // Link outputs
  output logic            sel_n_o,
  output logic            sck_o,
  output logic [3:0]      io_o
);
  initial {sel_n_o, sck_o, io_o} = 6'h20;
  // One 8-cycle link clock; data set while low, taken on the rise
  task automatic edge1(input logic [3:0] v, output logic [3:0] s);
    @(posedge clk_i) io_o <= v;
    repeat (3) @(posedge clk_i);
    sck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    s = io_i;
    @(posedge clk_i) sck_o <= 1'b0;
  endtask
  // Top lane carries the earliest bit; idle lanes keep toggling
  task automatic shift(input logic [39:0] v, input int n, input int ln);
    logic [3:0] d, s;
    for (int i = 0; i < n; i += ln) begin
      d = ~io_o;
      for (int j = 0; j < ln; j++)
        d[j] = v[n - i - ln + j];
      edge1(d, s);
    end
  endtask
  task automatic start();
    @(posedge clk_i) sel_n_o <= 1'b0;
  endtask
  // Released right after the last bit; gap covers the pin synchronisers
  task automatic desel();
    @(posedge clk_i) sel_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // flsq_host

// *** tb/tb_flsq_top.sv ***
// Bench: latch commands, read hand-off counts and register readout
`timescale 1ns/1ps
module tb_flsq_top;
  import flsq_pkg::*;
  logic        clk_i, rst_i, sel_n, sck, dtr, a4, perr, wel, clrf, rds;
  logic [3:0]  hio, dio, doe_n, pin, s;
  logic [7:0]  status, flag, vcfg, evcfg, exta;
  logic [15:0] nv;
  flsq_proto_t proto;
  flsq_rdreq_t req, got;
  int          errors, checks, cyc, nrd, ncl, k;
  // Read table: opcode, protocol, opcode lanes, address bits and lanes, cx, pulses
  logic [7:0]  rop [8] = '{OP_READ, OP_FAST4, OP_DIO, OP_QWORD, OP_QOF, OP_DOF, OP_FAST4,
                           OP_READ};
  flsq_proto_t rpr [8] = '{FLSQ_EXT, FLSQ_DUAL, FLSQ_EXT, FLSQ_EXT, FLSQ_QUAD, FLSQ_QUAD,
                           FLSQ_QUAD, FLSQ_EXT};
  int          rol [8] = '{1, 2, 1, 1, 4, 4, 4, 1};
  int          rn  [8] = '{24, 32, 24, 24, 24, 24, 32, 32};
  int          rl  [8] = '{1, 2, 2, 4, 4, 4, 4, 1};
  int          rcx [8] = '{31, 19, 19, 13, 7, 7, 9, 39};
  int          rp  [8] = '{1, 1, 1, 1, 1, 0, 1, 1};
  // Register reads and their expected streams, first bit already past
  logic [7:0]  gop [6] = '{OP_RDSR, OP_RDFSR, OP_RDNV, OP_RDVC, OP_RDEVC, OP_RDEXA};
  logic [23:0] gst [6] = '{24'ha6a6a6, 24'h818181, 24'h3c5a00, 24'hc3c3c3, 24'h969696,
                           24'h0f0f0f};
  // Pin level: the device where it drives, else the host
  for (genvar g = 0; g < 4; g++) begin : g_pin
    assign pin[g] = doe_n[g] ? hio[g] : dio[g];
  end
  flsq_host i_host (.clk_i(clk_i), .io_i(pin), .sel_n_o(sel_n), .sck_o(sck), .io_o(hio));
  flsq_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n), .sck_i(sck), .io_i(pin),
    .io_o(dio), .io_oe_n_o(doe_n), .proto_i(proto), .dtr_en_i(dtr), .addr4_en_i(a4),
    .prot_err_i(perr), .status_i(status), .flag_i(flag), .nvcfg_i(nv), .vcfg_i(vcfg),
    .evcfg_i(evcfg), .extaddr_i(exta), .wel_o(wel), .clr_flag_o(clrf), .rd_start_o(rds),
    .rd_req_o(req));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Start pulse lasts one cycle, so it is caught here; hang guard alongside
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rds === 1'b1) begin
      got <= req;
      nrd <= nrd + 1;
    end
    if (clrf === 1'b1) ncl <= ncl + 1;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input int ln, input int hold);
    i_host.start();
    i_host.shift(op, 8, ln);
    i_host.shift(40'h0, hold, ln);
    i_host.desel();
  endtask
  initial begin
    {rst_i, dtr, a4, perr} = 4'h8;
    proto = FLSQ_EXT;
    {status, flag, vcfg, evcfg, exta, nv} = 56'ha6_81_c3_96_0f_5a3c;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmd(OP_WREN, 1, 0);
    chk(wel, 1'b1);
    cmd(8'hff, 1, 0);
    chk(wel, 1'b1);
    i_host.start();
    i_host.shift(OP_WRDI, 4, 1);
    i_host.desel();
    chk(wel, 1'b1);
    perr <= 1'b1;
    cmd(OP_WRDI, 1, 0);
    chk(wel, 1'b1);
    cmd(OP_CLRF, 1, 0);
    chk(wel, 1'b0);
    chk(ncl, 1);
    perr <= 1'b0;
    proto <= FLSQ_QUAD;
    cmd(OP_WREN, 4, 4);
    chk(wel, 1'b0);
    proto <= FLSQ_DUAL;
    cmd(OP_WREN, 2, 0);
    chk(wel, 1'b1);
    $display("latch test done");
    for (int i = 0; i < 8; i++) begin
      proto <= rpr[i];
      a4    <= (i == 7); // Last row: 4-byte mode on a 3-byte opcode
      k = nrd;
      i_host.start();
      i_host.shift(rop[i], 8, rol[i]);
      i_host.shift(40'h12345678, rn[i], rl[i]);
      i_host.desel();
      chk(nrd - k, rp[i]);
      chk(got.cx, rcx[i]);
      chk(got.addr, rn[i] == 32 ? 32'h12345678 : 32'h345678);
      chk(got.abits, rn[i]);
    end
    $display("read test done");
    proto <= FLSQ_EXT;
    for (int i = 0; i < 6; i++) begin
      i_host.start();
      i_host.shift(gop[i], 8, 1);
      for (int b = 0; b < 23; b++) begin
        i_host.edge1(4'(b), s);
        chk(s[1], gst[i][22 - b]);
      end
      chk(doe_n, OEN_EXT);
      i_host.desel();
      chk({doe_n, dio}, {OEN_NONE, 4'h0});
    end
    $display("register test done");
    summarize();
  end
endmodule // tb_flsq_top
